// ===== rtl/lstb_pkg.sv
// constants, types and shared arithmetic of the leap-second time base
package lstb_pkg;
  // clock rate and local time base increments
  localparam int unsigned  CLK_HZ          = 10_000_000;
  localparam logic [29:0]  NS_PER_CLK      = 30'h64;        // 100 ns per clock
  localparam logic [29:0]  NS_PER_SEC      = 30'h3B9ACA00;  // one second in ns
  localparam logic [29:0]  NS_PER_US       = 30'h3E8;
  localparam logic [47:0]  US_PER_SEC      = 48'hF4240;
  // step threshold: larger offsets reset the time base instead of slewing
  localparam logic [63:0]  STEP_LIMIT_US   = 64'h1F4;       // 500 us
  localparam logic [63:0]  STEP_LIMIT_NS   = STEP_LIMIT_US * 64'h3E8;
  // calendar arithmetic, every hour taken as exactly 3600 s
  localparam logic [31:0]  SEC_PER_HOUR    = 32'hE10;
  localparam logic [31:0]  HOURS_PER_DAY   = 32'h18;
  localparam logic [31:0]  SEC_PER_DAY     = SEC_PER_HOUR * HOURS_PER_DAY;
  localparam logic [31:0]  DAYS_PER_YEAR   = 32'h16D;
  localparam logic [15:0]  EPOCH_YEAR      = 16'h7B2;       // 1970
  localparam logic [15:0]  LEAP_CYCLE_YR   = 16'h4;
  // scale offsets
  localparam logic [31:0]  GPS_TO_ATOMIC_S = 32'h13;        // atomic leads gps by 19 s
  localparam logic [15:0]  LEGACY_LEAP_S   = 16'hD;         // fixed count of legacy variant
  localparam logic [31:0]  ACQ_BOUNDARY_S  = 32'h2;         // restart grid after a step
  // wait for satellite leap correction: 12.5 minutes, held as tenths of a minute
  localparam logic [63:0]  LEAP_WAIT_DMIN  = 64'h7D;        // 125 tenths = 12.5 min
  localparam logic [63:0]  SEC_PER_DMIN    = 64'h6;
  localparam logic [63:0]  LEAP_WAIT_CYC   = LEAP_WAIT_DMIN * SEC_PER_DMIN * 64'(CLK_HZ);

  // which master drives the time base
  typedef enum logic {
    LSTB_SRC_GM,  // precision-time grandmaster
    LSTB_SRC_TC   // satellite-disciplined time code master
  } lstb_src_t;

  // signed distance a - b in nanoseconds
  function automatic logic signed [63:0] lstb_delta_ns(input logic [31:0] a_sec, input logic [29:0] a_ns,
                                                       input logic [31:0] b_sec, input logic [29:0] b_ns);
    logic [31:0] d32;
    d32 = a_sec - b_sec;
    return 64'(signed'(d32)) * signed'(64'(NS_PER_SEC)) + signed'(64'(a_ns)) - signed'(64'(b_ns));
  endfunction

  // utc second at which 1 january of the given year began
  function automatic logic [31:0] lstb_year_start(input logic [15:0] year);
    logic [31:0] yrs;
    logic [31:0] days;
    yrs  = 32'(year - EPOCH_YEAR);
    days = yrs * DAYS_PER_YEAR + 32'((year - EPOCH_YEAR + 16'h1) / LEAP_CYCLE_YR);
    return days * SEC_PER_DAY;
  endfunction
endpackage

// ===== rtl/lstb_stamp.sv
// packet timestamp former: year-relative microseconds and epoch seconds/nanoseconds
`timescale 1ns/1ps
`default_nettype none
module lstb_stamp (
  input  wire logic        clk,           // system clock
  input  wire logic        rst,           // synchronous reset, high
  input  wire logic        stamp_req,     // oldest data unit of a payload, gated by acquisition
  input  wire logic [31:0] utc_sec,       // current utc seconds since 1970
  input  wire logic [29:0] ns,            // nanoseconds within the second
  input  wire logic [15:0] year,          // year from the grandmaster
  output logic      [47:0] ts_year_us,    // year_relative_packet_format stamp
  output logic      [63:0] ts_epoch,      // epoch_packet_format stamp
  output logic             stamp_valid    // one-cycle pulse with fresh stamps
);
  typedef struct packed {
    logic [47:0] year_us;
    logic [63:0] epoch;
    logic        valid;
  } lstb_stamp_state_t;

  lstb_stamp_state_t st, st_next;  // state and its next value
  logic [31:0]       rel_sec;      // seconds since the year began

  // year start assumes uniform 3600 s hours, so a mid-year leap is ignored
  always_comb begin
    st_next       = st;
    rel_sec       = utc_sec - lstb_pkg::lstb_year_start(year);  // RQ4
    st_next.valid = stamp_req;
    if (stamp_req) begin
      st_next.year_us = 48'(rel_sec) * lstb_pkg::US_PER_SEC + 48'(ns / lstb_pkg::NS_PER_US);  // RQ11
      st_next.epoch   = {2'h0, ns, utc_sec};  // RQ12
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= st_next;
    end
  end

  assign ts_year_us  = st.year_us;
  assign ts_epoch    = st.epoch;
  assign stamp_valid = st.valid;

  property p_epoch_layout;
    @(posedge clk) disable iff (rst)
    stamp_req |=> stamp_valid && ts_epoch[31:0] == $past(utc_sec) && ts_epoch[61:32] == $past(ns);
  endproperty
  a_epoch_layout: assert property (p_epoch_layout) else $error("epoch stamp fields wrong");  // RQ12

  property p_year_rel;
    @(posedge clk) disable iff (rst)
    (stamp_req && utc_sec == lstb_pkg::lstb_year_start(year) && ns < lstb_pkg::NS_PER_US) |=> ts_year_us == 48'h0;
  endproperty
  a_year_rel: assert property (p_year_rel) else $error("year stamp not zero at year start");  // RQ4
endmodule  // lstb_stamp
`default_nettype wire

// ===== rtl/lstb_time_base.sv
// leap-second aware time base: sync, step/slew, leap handling, acquisition gating
// Contract
// [RQ1] utc equals reference time minus valid leap count
// [RQ2] leap insertion accepted at end of any month
// [RQ3] grandmaster gives only total utc offset seconds
// [RQ4] year start assumes every hour 3600 seconds
// [RQ5] year taken from the precision-time grandmaster
// [RQ6] apply satellite leap correction, stepping time back
// [RQ7] offset above 500 us resets time base
// [RQ8] after reset acquisition resumes at two-second boundary
// [RQ9] step expected after power-up and first lock
// [RQ10] leap count programmable; legacy holds fixed thirteen (code loads 13 once; satellite correction and insertion still change it)
// [RQ11] 48-bit microseconds since year start on oldest unit
// [RQ12] epoch stamp: seconds low word, nanoseconds high word
// [RQ13] atomic time leads satellite time by nineteen seconds
`timescale 1ns/1ps
`default_nettype none
module lstb_time_base #(
  parameter logic [39:0] LEAP_WAIT_CYCLES = 40'(lstb_pkg::LEAP_WAIT_CYC)  // wait for satellite leap fix
) (
  input  wire logic                clk,             // 10 MHz system clock
  input  wire logic                rst,             // synchronous power-up reset, high
  input  wire lstb_pkg::lstb_src_t src_sel,         // master that disciplines the time base
  input  wire logic                ptp_valid,       // grandmaster sync pulse
  input  wire logic [31:0]         ptp_sec,         // grandmaster atomic seconds
  input  wire logic [29:0]         ptp_ns,          // grandmaster nanoseconds
  input  wire logic [15:0]         ptp_utc_offset,  // grandmaster total utc offset, s
  input  wire logic [15:0]         ptp_year,        // grandmaster year
  input  wire logic                tc_valid,        // time code second marker pulse
  input  wire logic [31:0]         tc_gps_sec,      // satellite seconds at the marker
  input  wire logic                legacy_mode,     // fixed leap count variant
  input  wire logic [15:0]         leap_prog,       // programmed leap count
  input  wire logic                sat_leap_valid,  // satellite leap correction pulse
  input  wire logic [15:0]         sat_leap,        // corrected leap count
  input  wire logic                leap_insert_req, // announced leap insertion pulse
  input  wire logic                month_last_day,  // today is the last day of a month
  input  wire logic                stamp_req,       // oldest data unit of a payload
  output logic                     time_valid,      // time base has been set
  output logic                     acq_run,         // acquisition enabled
  output logic                     drop,            // pulse: data unit discarded in gap
  output logic      [31:0]         utc_sec,         // utc seconds since 1970
  output logic      [15:0]         leap_count,      // leap count in use, utc to atomic
  output logic      [15:0]         year,            // current year
  output logic      [7:0]          step_count,      // time base resets so far
  output logic                     leap_timeout,    // no satellite correction in time
  output logic      [47:0]         ts_year_us,      // year-relative stamp
  output logic      [63:0]         ts_epoch,        // epoch stamp
  output logic                     stamp_valid      // pulse with fresh stamps
);
  typedef struct packed {
    logic [31:0] sec;             // local atomic seconds
    logic [29:0] ns;              // local nanoseconds
    logic        valid;           // time base set at least once
    logic [19:0] slew_rem;        // ns still to slew
    logic        slew_dn;         // local clock ahead: slow down
    logic        init_done;       // leap count loaded after reset
    logic [15:0] gm_offset;       // last grandmaster offset
    logic [15:0] tc_leap;         // time code leap count, utc to gps
    logic        sat_seen;        // satellite correction received
    logic [39:0] wait_cnt;        // cycles waited for correction
    logic        leap_timeout;    // wait ran out
    logic        insert_pending;  // leap insertion armed
    logic        acq_run;         // acquisition running
    logic [15:0] year;            // year from grandmaster
    logic [7:0]  step_count;      // number of hard steps
    logic [31:0] utc_sec;         // registered utc
    logic [15:0] leap_out;        // registered leap count
    logic        drop;            // discard pulse
  } lstb_tb_state_t;

  lstb_tb_state_t     st, st_next;    // state and its next value
  logic [31:0]        eff_leap;       // atomic minus utc, seconds
  logic [31:0]        utc_now;        // utc of the current cycle
  logic               in_valid;       // sync from selected master
  logic [31:0]        in_sec;         // its atomic seconds
  logic [29:0]        in_ns;          // its nanoseconds
  logic signed [63:0] delta;          // incoming minus local, ns
  logic [63:0]        delta_mag;      // magnitude of delta
  logic               big_step;       // offset too large to slew
  logic [29:0]        inc;            // ns advance this cycle
  logic [30:0]        ns_sum;         // ns before wrap
  logic               sec_roll;       // second boundary this cycle
  logic               apply_insert;   // leap insertion applied now

  // leap count and incoming time of the selected master
  always_comb begin
    if (src_sel == lstb_pkg::LSTB_SRC_GM) begin
      eff_leap = {16'h0, st.gm_offset};  // only a total offset is known here  // RQ3
      in_valid = ptp_valid;
      in_sec   = ptp_sec;
      in_ns    = ptp_ns;
    end else begin
      eff_leap = {16'h0, st.tc_leap} + lstb_pkg::GPS_TO_ATOMIC_S;  // RQ13
      in_valid = tc_valid;
      in_sec   = tc_gps_sec + lstb_pkg::GPS_TO_ATOMIC_S;  // RQ13
      in_ns    = 30'h0;
    end
    utc_now   = st.sec - eff_leap;  // RQ1
    delta     = lstb_pkg::lstb_delta_ns(in_sec, in_ns, st.sec, st.ns);
    delta_mag = (delta < 0) ? 64'(-delta) : 64'(delta);
    big_step  = !st.valid || (delta_mag > lstb_pkg::STEP_LIMIT_NS);  // RQ7 RQ9
  end

  // next state: advance, slew or step, leap bookkeeping, acquisition gate
  always_comb begin
    st_next = st;
    // slewing trades a cycle of speed for continuity below the step limit
    inc = lstb_pkg::NS_PER_CLK;
    if (st.slew_rem != 20'h0) begin
      inc              = st.slew_dn ? 30'h0 : 30'(lstb_pkg::NS_PER_CLK << 1);
      st_next.slew_rem = (st.slew_rem > 20'(lstb_pkg::NS_PER_CLK)) ? st.slew_rem - 20'(lstb_pkg::NS_PER_CLK) : 20'h0;
    end
    ns_sum   = {1'b0, st.ns} + {1'b0, inc};
    sec_roll = ns_sum >= {1'b0, lstb_pkg::NS_PER_SEC};
    if (sec_roll) begin
      st_next.ns  = 30'(ns_sum - {1'b0, lstb_pkg::NS_PER_SEC});
      st_next.sec = st.sec + 32'h1;
      // restart only on the two-second grid
      if (st.valid && !st.acq_run && (st_next.sec % lstb_pkg::ACQ_BOUNDARY_S) == 32'h0) begin
        st_next.acq_run = 1'b1;  // RQ8
      end
    end else begin
      st_next.ns = ns_sum[29:0];
    end
    // leap insertion at the last second of any month, not only june or december
    apply_insert = sec_roll && st.insert_pending && month_last_day &&
                   (utc_now % lstb_pkg::SEC_PER_DAY) == (lstb_pkg::SEC_PER_DAY - 32'h1);  // RQ2
    if (apply_insert) begin
      st_next.tc_leap        = st.tc_leap + 16'h1;  // RQ2
      st_next.insert_pending = 1'b0;
    end
    // a fresh announcement in the same cycle re-arms: set wins over clear
    if (leap_insert_req) begin
      st_next.insert_pending = 1'b1;
    end
    // leap count loaded once after reset release
    if (!st.init_done) begin
      st_next.init_done = 1'b1;
      st_next.tc_leap   = legacy_mode ? lstb_pkg::LEGACY_LEAP_S : leap_prog;  // RQ10
    end
    // satellite correction wins; utc steps back by the difference
    if (sat_leap_valid) begin
      st_next.tc_leap  = sat_leap;  // RQ6
      st_next.sat_seen = 1'b1;
    end else if (!st.sat_seen && !st.leap_timeout) begin
      st_next.wait_cnt = st.wait_cnt + 40'h1;
      if (st_next.wait_cnt >= LEAP_WAIT_CYCLES) begin
        st_next.leap_timeout = 1'b1;  // RQ6
      end
    end
    // grandmaster carries year and offset with each sync
    if (ptp_valid) begin
      st_next.year      = ptp_year;  // RQ5
      st_next.gm_offset = ptp_utc_offset;  // RQ3
    end
    // synchronisation: reset the time base on a large offset, else slew
    if (in_valid) begin
      if (big_step) begin
        st_next.sec        = in_sec;  // RQ7
        st_next.ns         = in_ns;
        st_next.valid      = 1'b1;
        st_next.slew_rem   = 20'h0;
        st_next.acq_run    = 1'b0;  // RQ8
        st_next.step_count = st.step_count + 8'h1;  // RQ9
      end else begin
        st_next.slew_rem = delta_mag[19:0];
        st_next.slew_dn  = delta < 0;
      end
    end
    st_next.utc_sec  = utc_now;  // RQ1
    st_next.leap_out = eff_leap[15:0];
    st_next.drop     = stamp_req && !st.acq_run;  // RQ8
  end

  // single state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= st_next;
    end
  end

  // stamps are only formed while acquisition runs
  lstb_stamp i_lstb_stamp (
    .clk         (clk),
    .rst         (rst),
    .stamp_req   (stamp_req && st.acq_run),
    .utc_sec     (utc_now),
    .ns          (st.ns),
    .year        (st.year),
    .ts_year_us  (ts_year_us),
    .ts_epoch    (ts_epoch),
    .stamp_valid (stamp_valid)
  );

  assign time_valid   = st.valid;
  assign acq_run      = st.acq_run;
  assign drop         = st.drop;
  assign utc_sec      = st.utc_sec;
  assign leap_count   = st.leap_out;
  assign year         = st.year;
  assign step_count   = st.step_count;
  assign leap_timeout = st.leap_timeout;

  property p_utc;
    @(posedge clk) disable iff (rst)
    st.valid |=> utc_sec == $past(st.sec) - $past(eff_leap);
  endproperty
  a_utc: assert property (p_utc) else $error("utc not reference minus leap");  // RQ1

  property p_step;
    @(posedge clk) disable iff (rst)
    (in_valid && big_step) |=> st.sec == $past(in_sec) && !acq_run && step_count == $past(step_count) + 8'h1;
  endproperty
  a_step: assert property (p_step) else $error("large offset did not reset time base");  // RQ7

  property p_slew;
    @(posedge clk) disable iff (rst)
    (in_valid && !big_step) |=> step_count == $past(step_count);
  endproperty
  a_slew: assert property (p_slew) else $error("small offset caused a step");  // RQ7

  property p_restart;
    @(posedge clk) disable iff (rst)
    $rose(acq_run) |-> st.sec[0] == 1'b0 && st.sec != $past(st.sec);
  endproperty
  a_restart: assert property (p_restart) else $error("acquisition restarted off grid");  // RQ8

  property p_sat;
    @(posedge clk) disable iff (rst)
    sat_leap_valid |=> st.tc_leap == $past(sat_leap) && st.sat_seen;
  endproperty
  a_sat: assert property (p_sat) else $error("satellite leap not applied");  // RQ6

  property p_legacy;
    @(posedge clk) disable iff (rst)
    (!st.init_done && legacy_mode && !sat_leap_valid) |=> st.tc_leap == lstb_pkg::LEGACY_LEAP_S;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy leap count not loaded");  // RQ10

  property p_insert;
    @(posedge clk) disable iff (rst)
    (apply_insert && st.init_done && !sat_leap_valid) |=> st.tc_leap == $past(st.tc_leap) + 16'h1;
  endproperty
  a_insert: assert property (p_insert) else $error("leap insertion not applied");  // RQ2

  property p_tc_offset;
    @(posedge clk) disable iff (rst)
    (src_sel == lstb_pkg::LSTB_SRC_TC && tc_valid && big_step) |=> st.sec == $past(tc_gps_sec) + 32'h13;
  endproperty
  a_tc_offset: assert property (p_tc_offset) else $error("atomic not gps plus 19");  // RQ13

  property p_year;
    @(posedge clk) disable iff (rst)
    ptp_valid |=> year == $past(ptp_year);
  endproperty
  a_year: assert property (p_year) else $error("year not taken from grandmaster");  // RQ5

  property p_drop;
    @(posedge clk) disable iff (rst)
    (stamp_req && !acq_run) |=> drop && !stamp_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("data in gap not discarded");  // RQ8
endmodule  // lstb_time_base
`default_nettype wire

// ===== verification/lstb_master_model.sv
// far-side model: grandmaster syncs, time code markers and satellite leap corrections
`timescale 1ns/1ps
`default_nettype none
module lstb_master_model (
  input  wire logic        clk,            // system clock
  input  wire logic        load,           // set own atomic time
  input  wire logic [31:0] load_sec,       // atomic seconds to load
  input  wire logic [29:0] load_ns,        // nanoseconds to load
  input  wire logic        send_ptp,       // request one sync
  input  wire logic [29:0] skew_ns,        // error put on the sync time
  input  wire logic [15:0] offset,         // total utc offset to announce
  input  wire logic [15:0] gm_year,        // year to announce
  input  wire logic        send_tc,        // request one time code marker
  input  wire logic        send_leap,      // request one leap correction
  input  wire logic [15:0] leap_in,        // leap count to send
  output logic             ptp_valid,      // sync pulse
  output logic      [31:0] ptp_sec,        // atomic seconds
  output logic      [29:0] ptp_ns,         // nanoseconds
  output logic      [15:0] ptp_utc_offset, // total offset, nothing more
  output logic      [15:0] ptp_year,       // announced year
  output logic             tc_valid,       // marker pulse
  output logic      [31:0] tc_gps_sec,     // satellite seconds at marker
  output logic             sat_leap_valid, // correction pulse
  output logic      [15:0] sat_leap        // corrected count
);
  logic [31:0] sec_reg;  // own atomic seconds
  logic [29:0] ns_reg;   // own nanoseconds
  // quiet start so the design never samples unknowns
  initial begin
    sec_reg = '0;
    ns_reg = '0;
    ptp_valid = 1'b0;
    tc_valid = 1'b0;
    sat_leap_valid = 1'b0;
    ptp_sec = '0;
    ptp_ns = '0;
    ptp_utc_offset = '0;
    ptp_year = '0;
    tc_gps_sec = '0;
    sat_leap = '0;
  end
  // free-running atomic clock, same 100 ns step as the design
  always @(posedge clk) begin
    if (load) begin
      sec_reg <= load_sec;
      ns_reg  <= load_ns;
    end else if (ns_reg >= lstb_pkg::NS_PER_SEC - lstb_pkg::NS_PER_CLK) begin
      sec_reg <= sec_reg + 32'h1;
      ns_reg  <= ns_reg + lstb_pkg::NS_PER_CLK - lstb_pkg::NS_PER_SEC;
    end else begin
      ns_reg <= ns_reg + lstb_pkg::NS_PER_CLK;
    end
  end
  // fields mean something only with their pulse; between pulses they toggle so stale data shows up
  always @(posedge clk) begin
    ptp_valid      <= send_ptp;
    tc_valid       <= send_tc;
    sat_leap_valid <= send_leap;
    if (send_ptp) begin
      ptp_sec        <= sec_reg;
      ptp_ns         <= ns_reg + skew_ns;
      ptp_utc_offset <= offset;
      ptp_year       <= gm_year;
    end else begin
      ptp_sec        <= ~ptp_sec;
      ptp_ns         <= ~ptp_ns;
      ptp_utc_offset <= ~ptp_utc_offset;
      ptp_year       <= ~ptp_year;
    end
    tc_gps_sec <= send_tc ? sec_reg - lstb_pkg::GPS_TO_ATOMIC_S : ~tc_gps_sec;
    sat_leap   <= send_leap ? leap_in : ~sat_leap;
  end
endmodule  // lstb_master_model
`default_nettype wire

// ===== verification/test_lstb_time_base.sv
// self-checking bench for the leap-second time base
`timescale 1ns/1ps
`default_nettype none
module test_lstb_time_base;
  logic clk, rst, legacy_mode, stamp_req, load, send_ptp, send_tc, send_leap;  // bench-driven controls
  logic leap_insert_req, month_last_day;                                        // leap insertion controls
  lstb_pkg::lstb_src_t src_sel;                                                 // disciplining master
  logic [15:0] leap_prog, offset, gm_year, leap_in, ptp_utc_offset, ptp_year, sat_leap;  // counts and years
  logic [31:0] load_sec, ptp_sec, tc_gps_sec, utc_sec;                          // seconds
  logic [29:0] load_ns, skew_ns, ptp_ns;                                        // nanoseconds
  logic ptp_valid, tc_valid, sat_leap_valid, time_valid, acq_run, drop, leap_timeout, stamp_valid;
  logic [15:0] leap_count, year;                                                // design state
  logic [7:0]  step_count;                                                      // resets so far
  logic [47:0] ts_year_us;                                                      // year stamp
  logic [63:0] ts_epoch;                                                        // epoch stamp
  logic [31:0] y0;                                                              // start of test year
  int num_errors = 0;                                                           // mismatches
  int checked = 0;                                                              // comparisons
  // clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  lstb_master_model i_lstb_master_model (.clk(clk), .load(load), .load_sec(load_sec), .load_ns(load_ns),
    .send_ptp(send_ptp), .skew_ns(skew_ns), .offset(offset), .gm_year(gm_year), .send_tc(send_tc),
    .send_leap(send_leap), .leap_in(leap_in), .ptp_valid(ptp_valid), .ptp_sec(ptp_sec), .ptp_ns(ptp_ns),
    .ptp_utc_offset(ptp_utc_offset), .ptp_year(ptp_year), .tc_valid(tc_valid), .tc_gps_sec(tc_gps_sec),
    .sat_leap_valid(sat_leap_valid), .sat_leap(sat_leap));
  // short satellite wait keeps the run brief
  lstb_time_base #(.LEAP_WAIT_CYCLES(40'hC8)) i_lstb_time_base (.clk(clk), .rst(rst), .src_sel(src_sel),
    .ptp_valid(ptp_valid), .ptp_sec(ptp_sec), .ptp_ns(ptp_ns), .ptp_utc_offset(ptp_utc_offset),
    .ptp_year(ptp_year), .tc_valid(tc_valid), .tc_gps_sec(tc_gps_sec), .legacy_mode(legacy_mode),
    .leap_prog(leap_prog), .sat_leap_valid(sat_leap_valid), .sat_leap(sat_leap),
    .leap_insert_req(leap_insert_req), .month_last_day(month_last_day), .stamp_req(stamp_req),
    .time_valid(time_valid), .acq_run(acq_run), .drop(drop),
    .utc_sec(utc_sec), .leap_count(leap_count), .year(year), .step_count(step_count),
    .leap_timeout(leap_timeout), .ts_year_us(ts_year_us), .ts_epoch(ts_epoch), .stamp_valid(stamp_valid));
  // compare and count
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // utc second of 1 january, every day 86400 s, leap day each fourth year from 1972
  function automatic logic [31:0] yr_start(input logic [15:0] y);
    logic [31:0] d;
    d = 32'(y - 16'h7B2) * 32'h16D;
    for (logic [15:0] k = 16'h7B4; k < y; k += 16'h4) d += 32'h1;
    return d * 32'h15180;
  endfunction
  // reset held five cycles, mode inputs set alongside
  task automatic do_reset(input logic leg, input logic [15:0] prog);
    @(posedge clk);
    rst <= 1'b1;
    legacy_mode <= leg;
    leap_prog <= prog;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(64'({time_valid, acq_run, step_count, leap_timeout}), 64'h0);
    repeat (3) @(negedge clk);
  endtask
  // grandmaster path: step, gap, stamps, slew, second step
  task automatic t_ptp;
    do_reset(1'b0, 16'h25);
    y0 = yr_start(16'h7E1);
    @(posedge clk);
    {load, load_sec, load_ns} <= {1'b1, y0 + 32'hD2F00 + 32'h25, 30'h3B9A7BE0};
    @(posedge clk);
    {load, send_ptp, skew_ns, offset, gm_year} <= {1'b0, 1'b1, 30'h0, 16'h25, 16'h7E1};
    @(posedge clk);
    send_ptp <= 1'b0;
    repeat (3) @(negedge clk);
    check(64'({step_count, time_valid, acq_run}), 64'h6);
    check(64'(utc_sec), 64'(y0 + 32'hD2F00));
    check(64'({year, leap_count}), 64'h07E10025);
    @(posedge clk);
    stamp_req <= 1'b1;
    @(posedge clk);
    stamp_req <= 1'b0;
    @(negedge clk);
    check(64'({drop, stamp_valid}), 64'h2);
    for (int i = 0; i < 300 && acq_run !== 1'b1; i++) @(negedge clk);
    check(64'(acq_run), 64'h1);
    @(posedge clk);
    stamp_req <= 1'b1;
    @(posedge clk);
    stamp_req <= 1'b0;
    @(negedge clk);
    check(64'({stamp_valid, ts_epoch[63:62]}), 64'h4);
    check(64'(ts_epoch[31:0]), 64'(y0 + 32'hD2F01));
    check(64'(ts_year_us), 64'hD2F01 * 64'(lstb_pkg::US_PER_SEC));
    check(64'(ts_epoch[61:32]), 64'h64);
    @(posedge clk);
    {send_ptp, skew_ns} <= {1'b1, 30'h186A0};
    @(posedge clk);
    send_ptp <= 1'b0;
    repeat (3) @(negedge clk);
    check(64'({step_count, acq_run}), 64'h3);
    repeat (1100) @(posedge clk);
    {send_ptp, skew_ns} <= {1'b1, 30'hAAE60};
    @(posedge clk);
    send_ptp <= 1'b0;
    repeat (3) @(negedge clk);
    check(64'({step_count, acq_run}), 64'h4);
  endtask
  // time code path: legacy count, timeout, marker, satellite step back, programmed count
  task automatic t_tc;
    @(posedge clk);
    src_sel <= lstb_pkg::LSTB_SRC_TC;
    do_reset(1'b1, 16'h12);
    check(64'(leap_count), 64'h20);
    for (int i = 0; i < 260 && leap_timeout !== 1'b1; i++) @(negedge clk);
    check(64'(leap_timeout), 64'h1);
    @(posedge clk);
    {load, load_sec, load_ns} <= {1'b1, 32'h40000013, 30'h0};
    @(posedge clk);
    {load, send_tc} <= 2'b01;
    @(posedge clk);
    send_tc <= 1'b0;
    repeat (3) @(negedge clk);
    check(64'(utc_sec), 64'h3FFFFFF3);
    check(64'(step_count), 64'h1);
    @(posedge clk);
    {send_leap, leap_in} <= {1'b1, 16'h10};
    @(posedge clk);
    send_leap <= 1'b0;
    repeat (3) @(negedge clk);
    check(64'({leap_count, utc_sec}), 64'h00233FFFFFF0);
    do_reset(1'b0, 16'h12);
    check(64'(leap_count), 64'h25);
    // insertion armed, then applied at the utc day's last second of any month
    @(posedge clk);
    src_sel <= lstb_pkg::LSTB_SRC_GM;
    {load, load_sec, load_ns} <= {1'b1, 32'h1517F + 32'h25, 30'h3B9A7BE0};
    @(posedge clk);
    {load, send_ptp, leap_insert_req, month_last_day} <= 4'b0111;
    @(posedge clk);
    {send_ptp, leap_insert_req} <= 2'b00;
    repeat (210) @(posedge clk);
    src_sel <= lstb_pkg::LSTB_SRC_TC;
    repeat (2) @(negedge clk);
    check(64'(leap_count), 64'h26);
  endtask
  // verdict and end of run
  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog: tests need about 1760 cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test;
  end
  // main sequence
  initial begin
    {rst, legacy_mode, leap_prog, stamp_req, load, load_sec, load_ns} = '0;
    {send_ptp, skew_ns, offset, gm_year, send_tc, send_leap, leap_in} = '0;
    {leap_insert_req, month_last_day} = 2'b00;
    src_sel = lstb_pkg::LSTB_SRC_GM;
    t_ptp;
    t_tc;
    finish_test;
  end
endmodule  // test_lstb_time_base
`default_nettype wire
